//--- tb/pad_model.sv
// Board-side model of the eight pads: driver, pull resistors and external levels
module pad_model
	import gpio_irq_pkg::*;
(
	// Pad controls from the port
	input wire gpio_irq_pkg::pad_drive_type pad_drive,
	// Level the board would put on an undriven, unpulled pin
	input wire logic [7:0] ext_level,
	// Level seen back by the port
	output logic [7:0] pad_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// Per pin: own driver wins, then the pull resistor, then the board level
	// A floating pin is not modelled as X; the bench always commands a level
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_drive.pad_oe[i]) begin
				pad_in[i] = pad_drive.pad_out[i];
			end else if (pad_drive.pull_en[i]) begin
				pad_in[i] = pad_drive.pull_up[i];
			end else begin
				pad_in[i] = ext_level[i];
			end
		end
	end
endmodule : pad_model

//--- tb/port_pin_edge_interrupts_tb.sv
// Self-checking bench for the edge-interrupt port, driven over APB
module port_pin_edge_interrupts_tb;
	import gpio_irq_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic soft_reset = 1'b0;
	apb_req_type apb_req = '0;
	apb_rsp_type apb_rsp;
	logic global_irq_enable = 1'b0;
	logic port_irq_req;
	logic [7:0] periph_out = 8'h00;
	logic [7:0] pad_in;
	logic [7:0] ext_level = 8'h00;
	pad_drive_type pad_drive;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [31:0] rd_data;
	logic rd_err;
	logic [3:0] strb = 4'hf; // Byte lanes used by the next transfer

	// 10 MHz clock
	always #50 clk = ~clk;

	port_pin_edge_interrupts i_port_pin_edge_interrupts (
		.clk(clk), .rstn(rstn), .soft_reset(soft_reset),
		.apb_req(apb_req), .apb_rsp(apb_rsp),
		.global_irq_enable(global_irq_enable), .port_irq_req(port_irq_req),
		.periph_out(periph_out), .pad_in(pad_in), .pad_drive(pad_drive)
	);

	pad_model i_pad_model (.pad_drive(pad_drive), .ext_level(ext_level), .pad_in(pad_in));

	// Compare and count
	task chk(input logic [39:0] seen, input logic [39:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: strb};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		// No cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (apb_rsp.pready !== 1'b1);
		rd_data = apb_rsp.prdata;
		rd_err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk({8'h00, rd_data}, {8'h00, e});
	endtask : rd

	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	// Verdict and end of run
	task stop_test;
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	// Watchdog well beyond the expected few hundred cycles
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		stop_test;
	end

	// Main sequence
	initial begin
		wt(16);
		rstn <= 1'b1;
		@(posedge clk);
		chk(pad_drive, 40'h00_0000_0000);
		chk(port_irq_req, 1'b0);
		rd(ADDR_LOCK, 32'h0000_0001);
		rd(ADDR_IRQ_VECTOR, 32'h0000_0000);
		// Locked: software set works, clear refused, pin edges ignored
		wr(ADDR_IRQ_FLAGS, 32'h0000_0008);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0008);
		wr(ADDR_IRQ_FLAGS, 32'h0000_0000);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0008);
		ext_level <= 8'h04;
		wt(8);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0008);
		ext_level <= 8'h00;
		wt(8);
		// Unlock, then clear flags
		wr(ADDR_LOCK, 32'h0000_0000);
		wr(ADDR_IRQ_FLAGS, 32'h0000_0000);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0000);
		// Rising edge with polarity 0
		ext_level <= 8'h04;
		wt(8);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0004);
		// Polarity 0 to 1 while pin 5 reads 0 sets its flag
		wr(ADDR_EDGE_SELECT, 32'h0000_0020);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0024);
		wr(ADDR_IRQ_FLAGS, 32'h0000_0000);
		ext_level <= 8'h20;
		wt(8);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0000);
		ext_level <= 8'h00;
		wt(8);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0020);
		wr(ADDR_IRQ_FLAGS, 32'h0000_0000);
		// Enable gating, global gating, vector ignores disabled flags
		wr(ADDR_IRQ_ENABLE, 32'h0000_0020);
		wr(ADDR_IRQ_FLAGS, 32'h0000_0030);
		global_irq_enable <= 1'b1;
		wt(3);
		chk(port_irq_req, 1'b1);
		global_irq_enable <= 1'b0;
		wt(3);
		chk(port_irq_req, 1'b0);
		rd(ADDR_IRQ_VECTOR, 32'h0000_000C);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0010);
		rd(ADDR_IRQ_VECTOR, 32'h0000_0000);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0010);
		// All flags pending: served in priority order, request held between
		wr(ADDR_IRQ_ENABLE, 32'h0000_00FF);
		wr(ADDR_IRQ_FLAGS, 32'h0000_00FF);
		global_irq_enable <= 1'b1;
		wt(3);
		for (int i = 0; i < 8; i++) begin
			chk(port_irq_req, 1'b1);
			rd(ADDR_IRQ_VECTOR, 32'(2 * (i + 1)));
		end
		wt(3);
		chk(port_irq_req, 1'b0);
		// Byte lanes: upper-byte write keeps flags, low-byte write clears the top one
		wr(ADDR_IRQ_FLAGS, 32'h0000_0003);
		strb = 4'h2;
		wr(ADDR_IRQ_VECTOR, 32'h0000_0000);
		strb = 4'h1;
		wr(ADDR_IRQ_VECTOR, 32'h0000_0000);
		strb = 4'hf;
		rd(ADDR_IRQ_FLAGS, 32'h0000_0002);
		wr(ADDR_IRQ_FLAGS, 32'h0000_0000);
		// Function-selected pin raises no flag
		wr(ADDR_SEL_LOW, 32'h0000_0002);
		ext_level <= 8'h02;
		wt(8);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0000);
		wr(ADDR_SEL_LOW, 32'h0000_0000);
		rd(ADDR_INPUT, 32'h0000_0002);
		// Driving a pin high through output and direction writes
		wr(ADDR_OUTPUT, 32'h0000_0001);
		wr(ADDR_DIRECTION, 32'h0000_0001);
		wt(8);
		chk(pad_drive.pad_oe, 8'h01);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0001);
		// Unmapped address is refused
		apb(1'b0, 8'h3C, 32'h0000_0000);
		chk(rd_err, 1'b1);
		// Soft reset returns pins to inputs
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		wt(3);
		chk(pad_drive.pad_oe, 8'h00);
		rd(ADDR_DIRECTION, 32'h0000_0000);
		// Pull-up on pin 0 raises it; pin 7 handed to a peripheral puts its data on pad_out, with pad_oe still off
		wr(ADDR_PULL, 32'h0000_0001);
		periph_out <= 8'h80;
		wr(ADDR_SEL_HIGH, 32'h0000_0080);
		wt(8);
		chk(pad_drive, 40'h81_00FF_0101);
		rd(ADDR_IRQ_FLAGS, 32'h0000_0001);
		// Brownout in mid-run: pads released, lock armed, functions off
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk(pad_drive, 40'h00_0000_0000);
		rd(ADDR_LOCK, 32'h0000_0001);
		rd(ADDR_SEL_HIGH, 32'h0000_0000);
		stop_test;
	end
endmodule : port_pin_edge_interrupts_tb

//--- verilog/gpio_irq_pkg.sv
// Constants, register map and carrier types for the eight-line edge-interrupt port
package gpio_irq_pkg;

	// Port width
	localparam int PORT_BITS = 8;

	// Register byte addresses on the APB slave
	localparam logic [7:0] ADDR_INPUT = 8'h00;
	localparam logic [7:0] ADDR_OUTPUT = 8'h04;
	localparam logic [7:0] ADDR_DIRECTION = 8'h08;
	localparam logic [7:0] ADDR_PULL = 8'h0C;
	localparam logic [7:0] ADDR_SEL_LOW = 8'h10;
	localparam logic [7:0] ADDR_SEL_HIGH = 8'h14;
	localparam logic [7:0] ADDR_EDGE_SELECT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h20;
	localparam logic [7:0] ADDR_IRQ_VECTOR = 8'h24;
	localparam logic [7:0] ADDR_LOCK = 8'h28;

	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic RESET_LOCK = 1'b1;

	// Field positions
	localparam int LOCK_BIT = 0;
	localparam int STRB_LOW = 0;

	// Vector encoding: 0 when idle, 2*(n+1) for pin n
	localparam logic [4:0] VECTOR_NONE = 5'h00;
	localparam logic [4:0] VECTOR_STEP = 5'h02;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} apb_req_type;

	// APB answer to the master
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_type;

	// Drive of the eight pads
	typedef struct packed {
		logic [7:0] pad_out;
		logic [7:0] pad_oe;
		logic [7:0] pad_ie;
		logic [7:0] pull_en;
		logic [7:0] pull_up;
	} pad_drive_type;

endpackage : gpio_irq_pkg

//--- verilog/port_pin_edge_interrupts.sv
// Eight-line port with edge interrupt flags, priority vector and config lock
module port_pin_edge_interrupts (
	// Clock and resets
	input wire logic clk,
	input wire logic rstn,
	input wire logic soft_reset,
	// APB slave
	input wire gpio_irq_pkg::apb_req_type apb_req,
	output gpio_irq_pkg::apb_rsp_type apb_rsp,
	// Processor side
	input wire logic global_irq_enable,
	output logic port_irq_req,
	// Peripheral functions sharing the pads
	input wire logic [7:0] periph_out,
	// Pads
	input wire logic [7:0] pad_in,
	output gpio_irq_pkg::pad_drive_type pad_drive
);
	import gpio_irq_pkg::*;

	// Whole state of the block
	typedef struct packed {
		logic [7:0] sync1; // First synchroniser stage, read only by sync2
		logic [7:0] sync2; // Synchronised pin level
		logic [7:0] prev; // Previous synchronised sample
		logic [7:0] pin_output_value;
		logic [7:0] pin_direction;
		logic [7:0] pull_resistor_enable;
		logic [7:0] function_select_low;
		logic [7:0] function_select_high;
		logic [7:0] edge_polarity_select;
		logic [7:0] pin_irq_enable;
		logic [7:0] pin_edge_flag;
		logic io_config_lock;
		logic [4:0] vec_cap; // Vector captured in the setup cycle
		apb_rsp_type rsp;
		pad_drive_type drive;
		logic irq;
	} state_type;

	state_type st_q; // Registered state
	state_type st_d; // Next state

	logic [7:0] func_sel; // Pin handed to a peripheral
	logic [7:0] enabled_pending; // Flags whose enable is set
	logic [7:0] edge_set; // Flags set by pin edges
	logic [7:0] pol_set; // Flags set by polarity writes
	logic [7:0] sw_set; // Flags set by software
	logic [7:0] sw_clr; // Flags cleared by software
	logic [7:0] vec_clr; // Flag cleared by a vector access
	logic [4:0] vec_now; // Live vector value
	logic setup_cyc; // APB setup phase
	logic done_cyc; // APB access phase completing
	logic wr_low; // Write request touches the low byte, in any phase
	logic mapped; // Address decodes to a register

	// Priority encoder: lowest set bit wins, vector 2*(n+1)
	function automatic logic [4:0] vector_of(input logic [7:0] pend);
		logic [4:0] v;
		v = VECTOR_NONE;
		for (int i = PORT_BITS - 1; i >= 0; i--) begin
			if (pend[i]) begin
				v = 5'(VECTOR_STEP * 5'(i + 1));
			end
		end
		return v;
	endfunction : vector_of

	// Bit mask of the flag that a vector value names
	function automatic logic [7:0] flag_of(input logic [4:0] v);
		logic [7:0] m;
		m = RESET_BYTE;
		if (v != VECTOR_NONE) begin
			m[3'((v >> 1) - 5'd1)] = 1'b1;
		end
		return m;
	endfunction : flag_of

	// Bus phases; the slave answers in the first cycle of the access phase
	assign setup_cyc = apb_req.psel & ~apb_req.penable;
	assign done_cyc = apb_req.psel & apb_req.penable & st_q.rsp.pready;
	assign wr_low = apb_req.pwrite & apb_req.pstrb[STRB_LOW];

	// Any nonzero select bit takes the pin away from the edge logic
	assign func_sel = st_q.function_select_low | st_q.function_select_high;

	// Only enabled flags steer the vector and the request
	assign enabled_pending = st_q.pin_edge_flag & st_q.pin_irq_enable;
	assign vec_now = vector_of(enabled_pending);

	// Per-pin edge detection; every line of the port has it
	generate
		for (genvar g = 0; g < PORT_BITS; g++) begin : g_edge
			// Compare synchronized sample with previous one
			logic rise;
			logic fall;
			assign rise = st_q.sync2[g] & ~st_q.prev[g];
			assign fall = ~st_q.sync2[g] & st_q.prev[g];
			// Edges are ignored while locked (input buffers off) or function-selected
			assign edge_set[g] = ~st_q.io_config_lock & ~func_sel[g] &
				(st_q.edge_polarity_select[g] ? fall : rise);
		end
	endgenerate

	// Address decode
	always_comb begin
		unique case (apb_req.paddr)
			ADDR_INPUT, ADDR_OUTPUT, ADDR_DIRECTION, ADDR_PULL, ADDR_SEL_LOW,
			ADDR_SEL_HIGH, ADDR_EDGE_SELECT, ADDR_IRQ_ENABLE, ADDR_IRQ_FLAGS,
			ADDR_IRQ_VECTOR, ADDR_LOCK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Flag set and clear terms from software
	always_comb begin
		sw_set = RESET_BYTE;
		sw_clr = RESET_BYTE;
		vec_clr = RESET_BYTE;
		pol_set = RESET_BYTE;
		if (done_cyc && wr_low && apb_req.paddr == ADDR_IRQ_FLAGS) begin
			// Writing ones sets flags like an edge would
			sw_set = apb_req.pwdata[7:0];
			// Zeros clear, refused while locked
			if (!st_q.io_config_lock) begin
				sw_clr = ~apb_req.pwdata[7:0];
			end
		end
		if (done_cyc && wr_low && apb_req.paddr == ADDR_EDGE_SELECT) begin
			// 0->1 with input low, or 1->0 with input high, sets the flag
			pol_set = ~func_sel & ~st_q.io_config_lock &
				(apb_req.pwdata[7:0] ^ st_q.edge_polarity_select) &
				~(apb_req.pwdata[7:0] ^ ~st_q.sync2);
		end
		// A read, or a write that touches the low byte, clears the served flag
		if (done_cyc && apb_req.paddr == ADDR_IRQ_VECTOR &&
			(!apb_req.pwrite || wr_low) && !st_q.io_config_lock) begin
			vec_clr = flag_of(st_q.vec_cap);
		end
	end

	// Next-state logic
	always_comb begin
		st_d = st_q;
		// Two-stage synchroniser, then one-sample history
		st_d.sync1 = pad_in;
		st_d.sync2 = st_q.sync1;
		st_d.prev = st_q.sync2;
		// Set wins over clear in the same cycle
		st_d.pin_edge_flag = (st_q.pin_edge_flag & ~(sw_clr | vec_clr)) |
			edge_set | pol_set | sw_set;
		// Register writes take effect only at the completing edge
		if (done_cyc && wr_low) begin
			unique case (apb_req.paddr)
				// Pad level changes loop back through the edge detector
				ADDR_OUTPUT: st_d.pin_output_value = apb_req.pwdata[7:0];
				ADDR_DIRECTION: st_d.pin_direction = apb_req.pwdata[7:0];
				ADDR_PULL: st_d.pull_resistor_enable = apb_req.pwdata[7:0];
				ADDR_SEL_LOW: st_d.function_select_low = apb_req.pwdata[7:0];
				ADDR_SEL_HIGH: st_d.function_select_high = apb_req.pwdata[7:0];
				ADDR_EDGE_SELECT: st_d.edge_polarity_select = apb_req.pwdata[7:0];
				ADDR_IRQ_ENABLE: st_d.pin_irq_enable = apb_req.pwdata[7:0];
				// Lock only clears from software; brownout sets it
				ADDR_LOCK: st_d.io_config_lock = st_q.io_config_lock &
					apb_req.pwdata[LOCK_BIT];
				default: st_d.io_config_lock = st_q.io_config_lock;
			endcase
		end
		// Answer one cycle after setup; data captured at setup
		st_d.rsp.pready = setup_cyc;
		if (setup_cyc) begin
			st_d.vec_cap = vec_now;
			st_d.rsp.pslverr = ~mapped;
			unique case (apb_req.paddr)
				ADDR_INPUT: st_d.rsp.prdata = {24'h00_0000, st_q.sync2};
				ADDR_OUTPUT: st_d.rsp.prdata = {24'h00_0000, st_q.pin_output_value};
				ADDR_DIRECTION: st_d.rsp.prdata = {24'h00_0000, st_q.pin_direction};
				ADDR_PULL: st_d.rsp.prdata = {24'h00_0000, st_q.pull_resistor_enable};
				ADDR_SEL_LOW: st_d.rsp.prdata = {24'h00_0000, st_q.function_select_low};
				ADDR_SEL_HIGH: st_d.rsp.prdata = {24'h00_0000, st_q.function_select_high};
				ADDR_EDGE_SELECT: st_d.rsp.prdata = {24'h00_0000, st_q.edge_polarity_select};
				ADDR_IRQ_ENABLE: st_d.rsp.prdata = {24'h00_0000, st_q.pin_irq_enable};
				ADDR_IRQ_FLAGS: st_d.rsp.prdata = {24'h00_0000, st_q.pin_edge_flag};
				// Upper byte of the vector always reads zero
				ADDR_IRQ_VECTOR: st_d.rsp.prdata = {27'h000_0000, vec_now};
				ADDR_LOCK: st_d.rsp.prdata = {31'h0000_0000, st_q.io_config_lock};
				default: st_d.rsp.prdata = RESET_WORD;
			endcase
		end
		// Soft reset: inputs, functions off; lock and polarity untouched
		if (soft_reset) begin
			st_d.pin_direction = RESET_BYTE;
			st_d.pull_resistor_enable = RESET_BYTE;
			st_d.function_select_low = RESET_BYTE;
			st_d.function_select_high = RESET_BYTE;
			st_d.pin_irq_enable = RESET_BYTE;
			st_d.pin_edge_flag = RESET_BYTE;
		end
		// Pads stay released while the lock is set
		if (st_d.io_config_lock) begin
			st_d.drive.pad_oe = RESET_BYTE;
			st_d.drive.pad_ie = RESET_BYTE;
			st_d.drive.pull_en = RESET_BYTE;
			st_d.drive.pull_up = RESET_BYTE;
			st_d.drive.pad_out = RESET_BYTE;
		end else begin
			st_d.drive.pad_oe = st_d.pin_direction;
			st_d.drive.pad_ie = ~st_d.pin_direction;
			st_d.drive.pull_en = st_d.pull_resistor_enable & ~st_d.pin_direction;
			st_d.drive.pull_up = st_d.pin_output_value;
			// Per pin: a selected pin carries its peripheral's data, others the output register
			for (int i = 0; i < PORT_BITS; i++) begin
				st_d.drive.pad_out[i] = (st_d.function_select_low[i] |
					st_d.function_select_high[i]) ? periph_out[i] : st_d.pin_output_value[i];
			end
		end
		// Level request: any enabled flag still pending fires again after return
		st_d.irq = global_irq_enable & (|enabled_pending);
	end

	// State register; brownout lands pins high-Z with lock set
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
			st_q.io_config_lock <= RESET_LOCK;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flip-flops
	assign apb_rsp = st_q.rsp;
	assign pad_drive = st_q.drive;
	assign port_irq_req = st_q.irq;

	// Helper: access to the vector completing this cycle
	logic vec_access;
	assign vec_access = done_cyc && apb_req.paddr == ADDR_IRQ_VECTOR &&
		(!apb_req.pwrite || wr_low);

	// Helpers for the checks below, written from the rules rather than the flag logic
	logic [7:0] sel_idle; // Selected pins whose flag is still clear
	logic [7:0] pol_rise_expect; // Flags a 0-to-1 polarity write with the pin low must set
	assign sel_idle = func_sel & ~st_q.pin_edge_flag;
	assign pol_rise_expect = apb_req.pwdata[7:0] & ~st_q.edge_polarity_select & ~st_q.sync2 &
		~func_sel;

	// Checked on every pin, so any selected line exercises it, not just line 0
	property p_sel_blocks_edge;
		@(posedge clk) disable iff (!rstn)
		(!(done_cyc && apb_req.pwrite) && !soft_reset) |=>
			((st_q.pin_edge_flag & $past(sel_idle)) == RESET_BYTE);
	endproperty
	a_sel_blocks_edge: assert property (p_sel_blocks_edge)
		else $error("selected pin raised an edge flag");

	property p_vector_idle;
		@(posedge clk) disable iff (!rstn)
		(vec_now == VECTOR_NONE) == (enabled_pending == RESET_BYTE);
	endproperty
	a_vector_idle: assert property (p_vector_idle)
		else $error("vector idle value mismatch");

	property p_vector_top;
		@(posedge clk) disable iff (!rstn)
		enabled_pending[0] |-> vec_now == VECTOR_STEP;
	endproperty
	a_vector_top: assert property (p_vector_top)
		else $error("bit 0 did not win the vector");

	property p_irq_follow;
		@(posedge clk) disable iff (!rstn)
		(global_irq_enable && enabled_pending != RESET_BYTE) |=> port_irq_req;
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("request missing for enabled flag");

	property p_rise_sets;
		@(posedge clk) disable iff (!rstn)
		(!st_q.io_config_lock && !func_sel[0] && !st_q.edge_polarity_select[0]
			&& st_q.sync2[0] && !st_q.prev[0] && !soft_reset) |=> st_q.pin_edge_flag[0];
	endproperty
	a_rise_sets: assert property (p_rise_sets)
		else $error("rising edge did not set flag");

	property p_lock_keeps_flags;
		@(posedge clk) disable iff (!rstn)
		(st_q.io_config_lock && !soft_reset) |=>
			((st_q.pin_edge_flag & $past(st_q.pin_edge_flag)) == $past(st_q.pin_edge_flag));
	endproperty
	a_lock_keeps_flags: assert property (p_lock_keeps_flags)
		else $error("flag cleared while locked");

	property p_lock_pads;
		@(posedge clk) disable iff (!rstn)
		st_q.io_config_lock |-> (pad_drive.pad_oe == RESET_BYTE && pad_drive.pad_ie == RESET_BYTE);
	endproperty
	a_lock_pads: assert property (p_lock_pads)
		else $error("pads driven while locked");

	property p_soft_reset;
		@(posedge clk) disable iff (!rstn)
		soft_reset |=> (st_q.pin_direction == RESET_BYTE && func_sel == RESET_BYTE);
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("soft reset left outputs or functions");

	property p_vec_clear;
		@(posedge clk) disable iff (!rstn)
		(vec_access && !st_q.io_config_lock && st_q.vec_cap == VECTOR_STEP
			&& !edge_set[0] && !pol_set[0] && !sw_set[0]) |=> !st_q.pin_edge_flag[0];
	endproperty
	a_vec_clear: assert property (p_vec_clear)
		else $error("vector access did not clear top flag");

	// Upper-byte-only write is no low-byte access, so no flag may drop
	property p_vec_byte_keep;
		@(posedge clk) disable iff (!rstn)
		(done_cyc && apb_req.paddr == ADDR_IRQ_VECTOR && apb_req.pwrite
			&& !apb_req.pstrb[STRB_LOW] && !soft_reset) |=>
			((st_q.pin_edge_flag & $past(st_q.pin_edge_flag)) == $past(st_q.pin_edge_flag));
	endproperty
	a_vec_byte_keep: assert property (p_vec_byte_keep)
		else $error("upper byte vector write cleared a flag");

	// Polarity 0 to 1 while the pin reads low must leave the flag set
	property p_pol_sets;
		@(posedge clk) disable iff (!rstn)
		(done_cyc && wr_low && apb_req.paddr == ADDR_EDGE_SELECT && !st_q.io_config_lock
			&& !soft_reset) |=> (($past(pol_rise_expect) & ~st_q.pin_edge_flag) == RESET_BYTE);
	endproperty
	a_pol_sets: assert property (p_pol_sets)
		else $error("polarity write did not set flag");

	// Only a brownout arms the lock again; software can never re-arm it
	property p_lock_sticky;
		@(posedge clk) disable iff (!rstn)
		!st_q.io_config_lock |=> !st_q.io_config_lock;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("lock set again without brownout");

	// Global enable low silences the request one cycle later
	property p_irq_gated;
		@(posedge clk) disable iff (!rstn)
		!global_irq_enable |=> !port_irq_req;
	endproperty
	a_irq_gated: assert property (p_irq_gated)
		else $error("request without global enable");

	c_vec_access: cover property (@(posedge clk) disable iff (!rstn)
		vec_access && st_q.vec_cap != VECTOR_NONE);
	c_unlock: cover property (@(posedge clk) disable iff (!rstn)
		$fell(st_q.io_config_lock));
	c_retrigger: cover property (@(posedge clk) disable iff (!rstn)
		vec_access ##1 port_irq_req);
	c_byte_vector: cover property (@(posedge clk) disable iff (!rstn)
		done_cyc && apb_req.paddr == ADDR_IRQ_VECTOR && !apb_req.pstrb[STRB_LOW]);

endmodule : port_pin_edge_interrupts
